// *** rtl/gms_supervisor.sv ***
// Gripper motion supervisor: interlocks, grip outcome, limits, fast stop, event log
`timescale 1ns/1ps
`include "gms_regs.svh"
module gms_supervisor (
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   input  wire gms_pkg::gms_cmd_s      cmdIn,
   output gms_pkg::gms_resp_s          respOut,
   input  wire logic [15:0]            posRaw,
   input  wire logic                   atStop,
   input  wire logic                   partContact,
   input  wire logic                   forceReached,
   input  wire logic                   forceLost,
   input  wire logic                   moveDone,
   input  wire logic [7:0]             tempC,
   input  wire logic                   overloadRaw,
   input  wire logic [15:0]            outerOffset,
   input  wire logic [15:0]            nominalWidth,
   input  wire logic [15:0]            widthTol,
   input  wire logic [15:0]            clampTravel,
   input  wire logic [15:0]            travelMax,
   input  wire logic                   limitsEnable,
   input  wire logic [15:0]            limitMinus,
   input  wire logic [15:0]            limitPlus,
   input  wire logic                   todValid,
   input  wire logic [31:0]            todStamp,
   input  wire logic [3:0]             logRdAddr,
   output gms_pkg::gms_log_s           logRdData,
   output logic [3:0]                  logCount,
   output logic                        driveEnable,
   output logic                        moveRun,
   output logic [15:0]                 moveTarget,
   output logic [15:0]                 axisPos,
   output gms_pkg::gms_grip_e          gripState,
   output gms_pkg::gms_status_s        statusWord
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [7:0] tempMeta_reg;
   logic [7:0] tempSync_reg;
   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;
   logic       overload;
   logic       contact;
   logic       stopHit;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tempMeta_reg <= 8'h00;
         tempSync_reg <= 8'h00;
         pinMeta_reg  <= 3'h0;
         pinSync_reg  <= 3'h0;
      end else begin
         tempMeta_reg <= tempC;
         tempSync_reg <= tempMeta_reg;
         pinMeta_reg  <= {overloadRaw, partContact, atStop};
         pinSync_reg  <= pinMeta_reg;
      end
   end
   assign overload = pinSync_reg[2];
   assign contact  = pinSync_reg[1];
   assign stopHit  = pinSync_reg[0];

   // ------------------------------------------------------------
   // Position reference
   // ------------------------------------------------------------
   logic        homed_reg;
   logic        homing_reg;
   logic        homeOuter_reg;
   logic [15:0] refPos_reg;
   logic        halt_reg;

   // Base-jaw position; finger bodies not modelled
   assign axisPos = posRaw - refPos_reg;

   logic isCmd;
   logic isMove;
   logic isAck;
   logic isStop;
   assign isCmd  = cmdIn.valid;
   assign isAck  = isCmd && (cmdIn.opcode == `GMS_OP_ACK);
   assign isStop = isCmd && (cmdIn.opcode == `GMS_OP_STOP);
   assign isMove = isCmd && (cmdIn.opcode == `GMS_OP_HOME || cmdIn.opcode == `GMS_OP_PREPOS ||
                             cmdIn.opcode == `GMS_OP_GRASP || cmdIn.opcode == `GMS_OP_RELEASE);

   // ------------------------------------------------------------
   // Limit zones
   // ------------------------------------------------------------
   function automatic logic inZone(input logic [15:0] p, input logic [15:0] lo, input logic [15:0] hi);
      inZone = (p < lo) || (p > hi);
   endfunction : inZone

   logic curInZone;
   logic tgtInZone;
   logic escapeMove;
   logic tgtBad;
   assign curInZone  = limitsEnable && inZone(axisPos, limitMinus, limitPlus);
   assign tgtInZone  = limitsEnable && inZone(cmdIn.target, limitMinus, limitPlus);
   // Inside a zone a pre-position move is allowed only if it heads back out
   assign escapeMove = curInZone &&
                       ((axisPos < limitMinus) ? (cmdIn.target > axisPos) : (cmdIn.target < axisPos));
   assign tgtBad     = tgtInZone && !escapeMove;

   // Crossing: move running, was inside window, now outside
   logic wasInside_reg;
   logic crossing;
   assign crossing = moveRun && limitsEnable && wasInside_reg && curInZone;

   always_ff @(posedge clk_sys) begin
      if (!nrst) wasInside_reg <= 1'b0;
      else       wasInside_reg <= !curInZone;
   end

   // ------------------------------------------------------------
   // Faults and halt latch
   // ------------------------------------------------------------
   logic tempWarn;
   logic tempErr;
   logic curFault_reg;
   logic limitFault_reg;
   logic faultActive;
   logic haltSet;
   assign tempWarn    = tempSync_reg > `GMS_TEMP_WARN_C;
   assign tempErr     = tempSync_reg >= `GMS_TEMP_ERR_C;
   assign faultActive = tempErr || overload;
   assign haltSet     = crossing || tempErr || overload;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         halt_reg <= 1'b0;
      end else if (haltSet) begin
         halt_reg <= 1'b1;
      end else if (isAck && !faultActive) begin
         halt_reg <= 1'b0; // Ack with a fault present is ignored
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) curFault_reg <= 1'b0;
      else if (overload) curFault_reg <= 1'b1;
      else if (isAck) curFault_reg <= 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) limitFault_reg <= 1'b0;
      else if (crossing) limitFault_reg <= 1'b1;
      else if (isAck && !faultActive) limitFault_reg <= 1'b0;
   end

   // Drive power off as soon as halt latches
   assign driveEnable = !halt_reg && !haltSet;

   // ------------------------------------------------------------
   // Command acceptance
   // ------------------------------------------------------------
   logic [7:0] errCode;
   logic       accept;
   always_comb begin
      errCode = `GMS_ERR_NONE;
      if (isMove && halt_reg)
         errCode = `GMS_ERR_ACCESS;
      else if (isMove && !homed_reg && cmdIn.opcode != `GMS_OP_HOME)
         errCode = `GMS_ERR_NOTHOMED;
      else if (isMove && cmdIn.opcode == `GMS_OP_PREPOS && tgtBad)
         errCode = `GMS_ERR_RANGE;
   end
   assign accept = isMove && (errCode == `GMS_ERR_NONE);

   always_ff @(posedge clk_sys) begin
      if (!nrst) respOut <= '0;
      else begin
         respOut.valid <= isCmd;
         respOut.code  <= errCode;
      end
   end

   // ------------------------------------------------------------
   // Homing
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         homed_reg     <= 1'b0;
         homing_reg    <= 1'b0;
         homeOuter_reg <= 1'b0;
         refPos_reg    <= 16'h0000;
      end else if (accept && cmdIn.opcode == `GMS_OP_HOME) begin
         homed_reg     <= 1'b0;
         homing_reg    <= 1'b1;
         homeOuter_reg <= cmdIn.homeOuter;
      end else if (homing_reg && (haltSet || isStop)) begin
         homing_reg <= 1'b0;
      end else if (homing_reg && stopHit) begin
         homing_reg <= 1'b0;
         homed_reg  <= 1'b1;
         // Outer stop shifted so both variants share origin
         refPos_reg <= homeOuter_reg ? (posRaw - outerOffset) : posRaw;
      end
   end

   // ------------------------------------------------------------
   // Grip window and state machine
   // ------------------------------------------------------------
   logic [16:0] winLo;
   logic [16:0] winHi;
   logic        inWindow;
   logic        blockOff;
   logic [15:0] contactPos_reg;
   assign winLo    = {1'b0, nominalWidth} - {1'b0, widthTol} - {1'b0, clampTravel};
   assign winHi    = {1'b0, nominalWidth} + {1'b0, widthTol};
   assign inWindow = winLo[16] ? ({1'b0, axisPos} <= winHi)
                               : ({1'b0, axisPos} >= winLo && {1'b0, axisPos} <= winHi);
   assign blockOff = widthTol >= travelMax;

   gms_pkg::gms_grip_e state_reg;
   gms_pkg::gms_grip_e state_next;
   logic               clampDone;
   assign clampDone = (contactPos_reg - axisPos) >= clampTravel;

   always_comb begin
      state_next = state_reg;
      if (isStop && state_reg != gms_pkg::GS_ERROR) begin
         state_next = gms_pkg::GS_IDLE;
      end else if (haltSet && moveRun) begin
         state_next = gms_pkg::GS_ERROR;
      end else if (accept) begin
         unique case (cmdIn.opcode)
            `GMS_OP_PREPOS:  state_next = gms_pkg::GS_POSITION;
            `GMS_OP_GRASP:   state_next = gms_pkg::GS_GRASPING;
            `GMS_OP_RELEASE: state_next = gms_pkg::GS_RELEASE;
            default:         state_next = state_reg;
         endcase
      end else begin
         unique case (state_reg)
            gms_pkg::GS_GRASPING: begin
               if (contact && !blockOff && !inWindow)
                  state_next = gms_pkg::GS_ERROR;
               else if (contact && (forceReached || clampDone))
                  state_next = forceReached ? gms_pkg::GS_HOLDING : gms_pkg::GS_ERROR;
               else if (moveDone && !contact)
                  state_next = gms_pkg::GS_NOPART;
            end
            gms_pkg::GS_HOLDING:  if (forceLost) state_next = gms_pkg::GS_PARTLOST;
            gms_pkg::GS_RELEASE:  if (moveDone) state_next = gms_pkg::GS_IDLE;
            // No part detection or monitoring here
            gms_pkg::GS_POSITION: if (moveDone) state_next = gms_pkg::GS_IDLE;
            gms_pkg::GS_IDLE, gms_pkg::GS_PARTLOST,
            gms_pkg::GS_NOPART, gms_pkg::GS_ERROR: state_next = state_reg;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) state_reg <= gms_pkg::GS_IDLE;
      else       state_reg <= state_next;
   end
   assign gripState = state_reg;

   always_ff @(posedge clk_sys) begin
      if (!nrst) contactPos_reg <= 16'h0000;
      else if (state_reg == gms_pkg::GS_GRASPING && !contact) contactPos_reg <= axisPos;
   end

   logic axisBlk_reg;
   always_ff @(posedge clk_sys) begin
      if (!nrst) axisBlk_reg <= 1'b0;
      else if (state_reg == gms_pkg::GS_GRASPING && state_next == gms_pkg::GS_ERROR) axisBlk_reg <= 1'b1;
      else if (accept) axisBlk_reg <= 1'b0;
   end

   logic rangeErr_reg;
   always_ff @(posedge clk_sys) begin
      if (!nrst) rangeErr_reg <= 1'b0;
      else if (isCmd) rangeErr_reg <= (errCode == `GMS_ERR_RANGE);
   end

   // ------------------------------------------------------------
   // Motion outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         moveRun    <= 1'b0;
         moveTarget <= 16'h0000;
      end else if (haltSet || isStop) begin
         moveRun <= 1'b0;
      end else if (accept) begin
         moveRun    <= 1'b1;
         moveTarget <= cmdIn.target;
      end else if (moveDone || state_reg == gms_pkg::GS_HOLDING) begin
         moveRun <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) statusWord <= '0;
      else begin
         statusWord.homedFlag       <= homed_reg;
         statusWord.haltLatchedFlag <= halt_reg;
         statusWord.tempWarn        <= tempWarn;
         statusWord.tempErr         <= tempErr;
         statusWord.currentFault    <= curFault_reg;
         statusWord.rangeErr        <= rangeErr_reg;
         statusWord.axisBlock       <= axisBlk_reg || limitFault_reg;
      end
   end

   // ------------------------------------------------------------
   // Event log
   // ------------------------------------------------------------
   // Millisecond timebase, used when no time of day is present
   logic [14:0] msDiv_reg;
   logic [31:0] msCnt_reg;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         msDiv_reg <= 15'h0000;
         msCnt_reg <= 32'h0000_0000;
      end else if (msDiv_reg == 15'(`GMS_MS_CYCLES - 1)) begin
         msDiv_reg <= 15'h0000;
         msCnt_reg <= msCnt_reg + 32'h0000_0001;
      end else begin
         msDiv_reg <= msDiv_reg + 15'h0001;
      end
   end

   // One entry per cycle with a rising edge; overload wins over temp error, then warning, then limit
   logic [3:0] evNow;
   logic [3:0] evPrev_reg;
   logic [3:0] evRise;
   assign evNow  = {overload, tempErr, tempWarn, halt_reg && limitFault_reg};
   assign evRise = evNow & ~evPrev_reg;
   always_ff @(posedge clk_sys) begin
      if (!nrst) evPrev_reg <= 4'h0;
      else       evPrev_reg <= evNow;
   end

   logic [3:0] evKind;
   always_comb begin
      evKind = 4'h0;
      if (evRise[3])      evKind = `GMS_EV_CURRENT;
      else if (evRise[2]) evKind = `GMS_EV_TEMPERR;
      else if (evRise[1]) evKind = `GMS_EV_TEMPWARN;
      else if (evRise[0]) evKind = `GMS_EV_LIMIT;
   end

   gms_pkg::gms_log_s logMem [`GMS_LOG_DEPTH];
   logic [3:0]        wrPtr_reg;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         wrPtr_reg <= 4'h0;
         logCount  <= 4'h0;
      end else if (evKind != 4'h0) begin
         wrPtr_reg <= wrPtr_reg + 4'h1; // Wraps onto oldest entry
         if (logCount != 4'hF) logCount <= logCount + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (evKind != 4'h0)
         logMem[wrPtr_reg] <= '{kind: evKind, todValid: todValid,
                                stamp: todValid ? todStamp : msCnt_reg};
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) logRdData <= '0;
      else       logRdData <= logMem[logRdAddr];
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_not_homed;
      @(posedge clk_sys) disable iff (!nrst)
      (isMove && !homed_reg && !halt_reg && cmdIn.opcode != `GMS_OP_HOME) |=> respOut.code == `GMS_ERR_NOTHOMED;
   endproperty
   a_not_homed: assert property (p_not_homed) else $error("move accepted before homing");

   property p_access;
      @(posedge clk_sys) disable iff (!nrst)
      (isMove && halt_reg) |=> (respOut.valid && respOut.code == `GMS_ERR_ACCESS && !moveRun);
   endproperty
   a_access: assert property (p_access) else $error("move not refused during halt");

   property p_power;
      @(posedge clk_sys) disable iff (!nrst)
      halt_reg |-> !driveEnable;
   endproperty
   a_power: assert property (p_power) else $error("drive powered while halted");

   property p_flag;
      @(posedge clk_sys) disable iff (!nrst)
      $rose(halt_reg) |=> statusWord.haltLatchedFlag;
   endproperty
   a_flag: assert property (p_flag) else $error("halt flag missing");

   property p_ack_fault;
      @(posedge clk_sys) disable iff (!nrst)
      (halt_reg && faultActive) |=> halt_reg;
   endproperty
   a_ack_fault: assert property (p_ack_fault) else $error("halt cleared with fault present");

   property p_temp;
      @(posedge clk_sys) disable iff (!nrst)
      (tempSync_reg >= `GMS_TEMP_ERR_C) |=> halt_reg && statusWord.tempErr;
   endproperty
   a_temp: assert property (p_temp) else $error("over temperature did not halt");

   property p_stop;
      @(posedge clk_sys) disable iff (!nrst)
      (isStop && state_reg != gms_pkg::GS_ERROR) |=> gripState == gms_pkg::GS_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not return to idle");

   property p_range;
      @(posedge clk_sys) disable iff (!nrst)
      (accept && cmdIn.opcode == `GMS_OP_PREPOS) |-> !tgtBad;
   endproperty
   a_range: assert property (p_range) else $error("forbidden target accepted");

   property p_log;
      @(posedge clk_sys) disable iff (!nrst)
      ($rose(overload) && logCount != 4'hF) |=> logCount == $past(logCount) + 4'h1;
   endproperty
   a_log: assert property (p_log) else $error("overload not logged");
endmodule : gms_supervisor

// *** rtl/gms_regs.svh ***
// Constants and function list for the gripper motion supervisor
//
// Function
// - Motion commands are refused until homing has completed.
// - Homing drives to inner or outer stop and stores measured position as reference.
// - Outer homing subtracts the calibrated offset from the reference.
// - Grip valid only if width lies within tolerance plus clamping travel window.
// - After detection, fingers move on for force only within the clamping travel.
// - Grasp ending without a part gives the no-part-found state.
// - Contact outside the valid window is an axis block and gives the error state.
// - Part detection and grip monitoring are off during pre-positioning.
// - Tolerance set to full travel disables axis-block detection.
// - Pre-position target inside an enabled limit zone gets a range error, no motion.
// - Crossing into an enabled limit zone during motion raises a fast stop.
// - Fingers inside a zone when enabled may only move out of it; only pre-position moves are checked.
// - Limits compare against the base-jaw position, not finger bodies.
// - Status word shows the halt flag while a fast stop is active.
// - Latched halt refuses every move with access denied until cleared.
// - Entering fast stop removes drive power.
// - Acknowledge opcode 24h clears a fast stop.
// - Every fast stop writes an event log entry; events rising in one cycle share a single entry.
// - Log entries carry time of day or milliseconds; oldest entry overwritten when full.
// - Housing above 65 C gives a logged temperature warning; a warning rising in the same cycle as temp error or overload is not logged.
// - At 70 C enter temperature error, fast stop, ack only once cooled.
// - Drive overload fast-stops, flags current fault, logs, ack only once cleared.
// - Stop command returns any state except error to idle at once.
// - Homed flag in the status word, separate from gripper state.
`ifndef GMS_REGS_SVH
`define GMS_REGS_SVH
`define GMS_POS_W        16
`define GMS_TEMP_W       8
`define GMS_TEMP_WARN_C  8'h41
`define GMS_TEMP_ERR_C   8'h46
`define GMS_OP_HOME      8'h20
`define GMS_OP_PREPOS    8'h21
`define GMS_OP_STOP      8'h22
`define GMS_OP_ACK       8'h24
`define GMS_OP_GRASP     8'h25
`define GMS_OP_RELEASE   8'h26
`define GMS_CLK_HZ       25000000
`define GMS_MS_CYCLES    (`GMS_CLK_HZ / 1000)
`define GMS_MS_CNT_W     15
`define GMS_LOG_DEPTH    16
`define GMS_LOG_AW       4
`define GMS_ERR_NONE     8'h00
`define GMS_ERR_ACCESS   8'h01
`define GMS_ERR_RANGE    8'h02
`define GMS_ERR_NOTHOMED 8'h03
`define GMS_EV_LIMIT     4'h1
`define GMS_EV_TEMPWARN  4'h2
`define GMS_EV_TEMPERR   4'h3
`define GMS_EV_CURRENT   4'h4
`endif

// *** rtl/gms_pkg.sv ***
// Types shared by the gripper motion supervisor
package gms_pkg;
   typedef enum logic [7:0] {
      GS_IDLE     = 8'h01,
      GS_GRASPING = 8'h02,
      GS_HOLDING  = 8'h04,
      GS_PARTLOST = 8'h08,
      GS_NOPART   = 8'h10,
      GS_RELEASE  = 8'h20,
      GS_POSITION = 8'h40,
      GS_ERROR    = 8'h80
   } gms_grip_e;

   typedef struct packed {
      logic        valid;
      logic [7:0]  opcode;
      logic [15:0] target;
      logic        homeOuter;
   } gms_cmd_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } gms_resp_s;

   typedef struct packed {
      logic        homedFlag;
      logic        haltLatchedFlag;
      logic        tempWarn;
      logic        tempErr;
      logic        currentFault;
      logic        rangeErr;
      logic        axisBlock;
   } gms_status_s;

   typedef struct packed {
      logic [3:0]  kind;
      logic        todValid;
      logic [31:0] stamp;
   } gms_log_s;
endpackage : gms_pkg

// *** test/gms_host_model.sv ***
// Host controller model that issues supervisor commands
`timescale 1ns/1ps
module gms_host_model (
   input  wire logic               clk_sys,
   input  wire logic               go,
   input  wire logic [7:0]         op,
   input  wire logic [15:0]        tgt,
   input  wire logic               outer,
   output gms_pkg::gms_cmd_s       cmdIn,
   input  wire gms_pkg::gms_resp_s respOut,
   output logic [7:0]              code,
   output logic                    done
);
   initial cmdIn = '0;
   // ---------------------------------------------
   // One-cycle command pulse, answer one cycle on
   // ---------------------------------------------
   always_ff @(posedge clk_sys) begin
      // Idle fields toggle so stale values never look valid
      if (go) begin
         cmdIn <= {1'b1, op, tgt, outer};
      end else begin
         cmdIn <= {1'b0, ~cmdIn[24:0]};
      end
      done <= respOut.valid;
      code <= respOut.code;
   end
endmodule : gms_host_model

// *** test/gms_supervisor_tb_top.sv ***
// Self-checking bench for the gripper motion supervisor
`timescale 1ns/1ps
module gms_supervisor_tb_top;
   logic clk_sys, nrst, go, outer, done, atStop, overloadRaw, todValid;
   logic [7:0] op, code, tempC;
   logic [15:0] tgt, posRaw, t;
   logic [31:0] stampVal;
   logic [3:0] logRdAddr, logCount;
   logic driveEnable, moveRun;
   logic partContact, forceReached, forceLost, moveDone, limitsEnable;
   logic [15:0] outerOffset, limitMinus;
   logic [15:0] axisPos, moveTarget;
   gms_pkg::gms_cmd_s cmdIn;
   gms_pkg::gms_resp_s respOut;
   gms_pkg::gms_log_s logRdData;
   gms_pkg::gms_grip_e gripState;
   gms_pkg::gms_status_s statusWord;
   int miscompares = 0, checked = 0, seed = 32'h4ee5, i;
   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   gms_host_model host_u (.clk_sys(clk_sys), .go(go), .op(op), .tgt(tgt), .outer(outer),
      .cmdIn(cmdIn), .respOut(respOut), .code(code), .done(done));
   gms_supervisor dut_u (.clk_sys(clk_sys), .nrst(nrst), .cmdIn(cmdIn), .respOut(respOut),
      .posRaw(posRaw), .atStop(atStop), .partContact(partContact), .forceReached(forceReached),
      .forceLost(forceLost), .moveDone(moveDone), .tempC(tempC), .overloadRaw(overloadRaw),
      .outerOffset(outerOffset), .nominalWidth(16'h0400), .widthTol(16'h0040),
      .clampTravel(16'h0020), .travelMax(16'hFFFF), .limitsEnable(limitsEnable),
      .limitMinus(limitMinus), .limitPlus(16'h0F00), .todValid(todValid),
      .todStamp(stampVal), .logRdAddr(logRdAddr), .logRdData(logRdData),
      .logCount(logCount), .driveEnable(driveEnable), .moveRun(moveRun),
      .moveTarget(moveTarget), .axisPos(axisPos), .gripState(gripState),
      .statusWord(statusWord));
   // ---------------------------------------------
   // Shared checks
   // ---------------------------------------------
   task automatic stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic fail;
      miscompares++;
      stop_test();
   endtask : fail
   // Code 8'hFF means the answer is not judged
   task automatic cmd(input logic [7:0] o, input logic [15:0] g, input logic [7:0] exp);
      @(posedge clk_sys);
      go <= 1'b1;
      op <= o;
      tgt <= g;
      @(posedge clk_sys);
      go <= 1'b0;
      for (int k = 0; k <= 6; k++) begin
         @(posedge clk_sys);
         #1;
         if (done) break;
         if (k == 6) fail();
      end
      if (exp != 8'hFF) chk(code, exp);
   endtask : cmd
   task automatic waitBit(input int b, input logic v);
      for (int k = 0; k <= 20; k++) begin
         @(posedge clk_sys);
         #1;
         if (statusWord[b] === v) break;
         if (k == 20) fail();
      end
   endtask : waitBit
   task automatic home(input logic o, input logic [15:0] p);
      outer <= o;
      posRaw <= p;
      cmd(8'h20, 16'h0000, 8'h00);
      atStop <= 1'b1;
      waitBit(6, 1'b1);
      atStop <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : home
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {nrst, go, outer, atStop, overloadRaw, todValid, op, tgt} = '0;
      {partContact, forceReached, forceLost, moveDone} = 4'h0;
      limitsEnable = 1'b1;
      outerOffset = 16'h0200;
      limitMinus = 16'h0100;
      tempC = 8'h19;
      posRaw = 16'h1234;
      logRdAddr = 4'h0;
      stampVal = $random(seed);
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      todValid <= 1'b1;
      cmd(8'h25, 16'h0000, 8'h03);
      chk(statusWord.homedFlag, 1'b0);
      home(1'b0, 16'h3000);
      chk(axisPos, 16'h0000);
      home(1'b1, 16'h5000);
      chk(axisPos, 16'h0200);
      cmd(8'h25, 16'h0000, 8'h00);
      chk(gripState, gms_pkg::GS_GRASPING);
      cmd(8'h22, 16'h0000, 8'hFF);
      chk(gripState, gms_pkg::GS_IDLE);
      for (i = 0; i < 8; i++) begin
         t = (i < 4) ? 16'h00FF + 16'(i) * 16'h0601 : 16'($random(seed));
         cmd(8'h21, t, (t < 16'h0100 || t > 16'h0F00) ? 8'h02 : 8'h00);
         cmd(8'h22, 16'h0000, 8'hFF);
      end
      // Warm up through the warning band so warning and error log apart
      tempC <= 8'h43;
      repeat (4) @(posedge clk_sys);
      tempC <= 8'h46;
      waitBit(5, 1'b1);
      chk(statusWord.tempErr, 1'b1);
      chk(driveEnable, 1'b0);
      cmd(8'h21, 16'h0400, 8'h01);
      cmd(8'h24, 16'h0000, 8'hFF);
      repeat (3) @(posedge clk_sys);
      chk(statusWord.haltLatchedFlag, 1'b1);
      tempC <= 8'h3C;
      repeat (4) @(posedge clk_sys);
      cmd(8'h24, 16'h0000, 8'hFF);
      waitBit(5, 1'b0);
      overloadRaw <= 1'b1;
      waitBit(5, 1'b1);
      chk(statusWord.currentFault, 1'b1);
      overloadRaw <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cmd(8'h24, 16'h0000, 8'hFF);
      waitBit(5, 1'b0);
      chk(driveEnable, 1'b1);
      chk(logCount, 4'h3);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(logRdData.stamp, stampVal);
      stop_test();
   end
endmodule : gms_supervisor_tb_top
